//--- src/hpm_pkg.sv
// package: constants and carrier types for the host port pin mux
package hpm_pkg;
   localparam int unsigned NUM_PINS = 4;
   // pin index positions
   localparam int unsigned PIN_ADDR_LO = 0;
   localparam int unsigned PIN_DIR_RD  = 1;
   localparam int unsigned PIN_STROBE  = 2;
   localparam int unsigned PIN_CS_HI   = 3;
   // reset values
   localparam logic [3:0] RST_GPIO_DIR = 4'h0;
   localparam logic [3:0] RST_GPIO_EN  = 4'h0;
   localparam logic [3:0] RST_GPIO_OUT = 4'h0;
   localparam logic       RST_POL_ACTIVE_HIGH = 1'b0;

   typedef enum logic [1:0] {
      HPM_GPIO_OFF,
      HPM_GPIO_IN,
      HPM_GPIO_OUT,
      HPM_HOST
   } hpm_pin_mode_type;

   // configuration carrier
   typedef struct packed {
      logic       host_function_mode;
      logic       mux_bus;
      logic       double_strobe;
      logic       rd_pol_high;
      logic       ds_pol_high;
      logic       cs_pol_high;
      logic [3:0] gpio_en;
      logic [3:0] gpio_dir;
      logic [3:0] gpio_out;
   } hpm_cfg_type;

   // decoded host-bus inputs, all active high
   typedef struct packed {
      logic host_addr_bit_zero;
      logic host_addr_bit_two;
      logic host_addr_bit_nine;
      logic host_addr_bit_ten;
      logic host_read_write_dir;
      logic host_read_strobe;
      logic host_combined_strobe;
      logic host_write_strobe;
      logic host_chip_select;
   } hpm_host_type;
endpackage

//--- src/hpm_pin_cell.sv
// one shared pin: gpio direction, drive and input capture
`timescale 1ns/10ps
module hpm_pin_cell
   import hpm_pkg::*;
(
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   input  wire logic host_sel_in,
   input  wire logic gpio_en_in,
   input  wire logic gpio_dir_in,
   input  wire logic gpio_out_in,
   input  wire logic pin_in,
   output logic      pin_out,
   output logic      pin_oe_n_out,
   output logic      gpio_in_out,
   output logic      host_level_out,
   output hpm_pin_mode_type mode_out
);
   hpm_pin_mode_type mode_next;

   always_comb begin
      if (host_sel_in) begin
         mode_next = HPM_HOST;
      end else if (!gpio_en_in) begin
         mode_next = HPM_GPIO_OFF;
      end else if (gpio_dir_in) begin
         mode_next = HPM_GPIO_OUT;
      end else begin
         mode_next = HPM_GPIO_IN;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         mode_out <= HPM_GPIO_OFF;
      end else begin
         mode_out <= mode_next;
      end
   end

   // drive: only gpio output mode enables the driver (low enable)
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         pin_out      <= 1'b0;
         pin_oe_n_out <= 1'b1;
      end else begin
         pin_out      <= (mode_next == HPM_GPIO_OUT) ? gpio_out_in : 1'b0;
         pin_oe_n_out <= (mode_next != HPM_GPIO_OUT);
      end
   end

   // capture: gpio input only in input mode, host level only in host mode
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         gpio_in_out    <= 1'b0;
         host_level_out <= 1'b0;
      end else begin
         gpio_in_out    <= (mode_next == HPM_GPIO_IN) ? pin_in : 1'b0;
         host_level_out <= (mode_next == HPM_HOST) ? pin_in : 1'b0;
      end
   end
endmodule

//--- src/hpm_top.sv
// host port pin function select: four shared pins plus address-zero pin
//
// Function
// - host mode: pin0 is address bit two or nine
// - pin1 is read/write dir or read strobe
// - pin2 is combined strobe or write strobe
// - pin3 is chip select or address bit ten
// - read strobe polarity configurable, reset active low
// - data strobes polarity configurable, reset active low
// - chip select polarity configurable, reset active low
// - gpio pins each input, output or disconnected
// - after reset all pins gpio disconnected
// - non-mux host mode takes address bit zero
`timescale 1ns/10ps
module hpm_top
   import hpm_pkg::*;
(
   input  wire logic          clk_in,
   input  wire logic          rst_n_in,
   input  wire hpm_cfg_type   cfg_in,
   input  wire logic [3:0]    pin_in,
   input  wire logic          addr_zero_pin_in,
   output logic [3:0]         pin_out,
   output logic [3:0]         pin_oe_n_out,
   output logic [3:0]         gpio_in_out,
   output hpm_host_type       host_out,
   output logic               host_active_out
);
   logic [3:0]       lvl;
   logic [3:0]       gin;
   logic [3:0]       pout;
   logic [3:0]       poe_n;
   hpm_pin_mode_type mode [NUM_PINS];
   hpm_cfg_type      cfg_reg;
   hpm_host_type     host_next;
   logic             addr_zero_reg;

   // configuration held in flops so reset gives gpio-off defaults
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         cfg_reg.host_function_mode <= 1'b0;
         cfg_reg.mux_bus            <= 1'b0;
         cfg_reg.double_strobe      <= 1'b0;
         cfg_reg.rd_pol_high        <= RST_POL_ACTIVE_HIGH;
         cfg_reg.ds_pol_high        <= RST_POL_ACTIVE_HIGH;
         cfg_reg.cs_pol_high        <= RST_POL_ACTIVE_HIGH;
         cfg_reg.gpio_en            <= RST_GPIO_EN;
         cfg_reg.gpio_dir           <= RST_GPIO_DIR;
         cfg_reg.gpio_out           <= RST_GPIO_OUT;
      end else begin
         cfg_reg <= cfg_in;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_PINS; g++) begin : g_pin
         hpm_pin_cell u_cell (
            .clk_in         (clk_in),
            .rst_n_in       (rst_n_in),
            .host_sel_in    (cfg_reg.host_function_mode),
            .gpio_en_in     (cfg_reg.gpio_en[g]),
            .gpio_dir_in    (cfg_reg.gpio_dir[g]),
            .gpio_out_in    (cfg_reg.gpio_out[g]),
            .pin_in         (pin_in[g]),
            .pin_out        (pout[g]),
            .pin_oe_n_out   (poe_n[g]),
            .gpio_in_out    (gin[g]),
            .host_level_out (lvl[g]),
            .mode_out       (mode[g])
         );
      end
   endgenerate

   assign pin_out      = pout;
   assign pin_oe_n_out = poe_n;
   assign gpio_in_out  = gin;

   // address-zero pin sampled only in non-mux host mode
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         addr_zero_reg <= 1'b0;
      end else if (cfg_reg.host_function_mode && !cfg_reg.mux_bus) begin
         addr_zero_reg <= addr_zero_pin_in;
      end else begin
         addr_zero_reg <= 1'b0;
      end
   end

   // decode captured pin levels into host-bus roles
   always_comb begin
      host_next = '0;
      if (mode[PIN_ADDR_LO] == HPM_HOST) begin
         host_next.host_addr_bit_zero = addr_zero_reg;
         if (cfg_reg.mux_bus) begin
            host_next.host_addr_bit_nine = lvl[PIN_ADDR_LO];
         end else begin
            host_next.host_addr_bit_two = lvl[PIN_ADDR_LO];
         end
         if (cfg_reg.double_strobe) begin
            host_next.host_read_strobe =
               lvl[PIN_DIR_RD] ~^ cfg_reg.rd_pol_high;
            host_next.host_write_strobe =
               lvl[PIN_STROBE] ~^ cfg_reg.ds_pol_high;
         end else begin
            host_next.host_read_write_dir = lvl[PIN_DIR_RD];
            host_next.host_combined_strobe =
               lvl[PIN_STROBE] ~^ cfg_reg.ds_pol_high;
         end
         if (cfg_reg.mux_bus) begin
            host_next.host_addr_bit_ten = lvl[PIN_CS_HI];
         end else begin
            host_next.host_chip_select =
               lvl[PIN_CS_HI] ~^ cfg_reg.cs_pol_high;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         host_out        <= '0;
         host_active_out <= 1'b0;
      end else begin
         host_out        <= host_next;
         host_active_out <= (mode[PIN_ADDR_LO] == HPM_HOST);
      end
   end

   a_gpio_no_host: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !cfg_reg.host_function_mode ##2 !cfg_reg.host_function_mode
      |-> host_out == '0)
      else $error("host output decoded in gpio mode");
   a_addr_two_path: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (mode[0] == HPM_HOST && !cfg_reg.mux_bus)
      |=> host_out.host_addr_bit_two == $past(lvl[0]))
      else $error("address bit two mismatch");
   a_addr_nine_path: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (mode[0] == HPM_HOST && cfg_reg.mux_bus)
      |=> host_out.host_addr_bit_nine == $past(lvl[0]))
      else $error("address bit nine mismatch");
   a_rd_strobe_pol: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (mode[1] == HPM_HOST && cfg_reg.double_strobe)
      |=> host_out.host_read_strobe ==
          ($past(lvl[1]) == $past(cfg_reg.rd_pol_high)))
      else $error("read strobe polarity wrong");
   a_rw_dir_path: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (mode[1] == HPM_HOST && !cfg_reg.double_strobe)
      |=> host_out.host_read_write_dir == $past(lvl[1]))
      else $error("read write direction mismatch");
   a_ds_strobe_pol: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (mode[2] == HPM_HOST && !cfg_reg.double_strobe)
      |=> host_out.host_combined_strobe ==
          ($past(lvl[2]) == $past(cfg_reg.ds_pol_high)))
      else $error("combined strobe wrong");
   a_wr_strobe_pol: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (mode[2] == HPM_HOST && cfg_reg.double_strobe)
      |=> host_out.host_write_strobe ==
          ($past(lvl[2]) == $past(cfg_reg.ds_pol_high)))
      else $error("write strobe wrong");
   a_cs_pol_path: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (mode[3] == HPM_HOST && !cfg_reg.mux_bus)
      |=> host_out.host_chip_select ==
          ($past(lvl[3]) == $past(cfg_reg.cs_pol_high)))
      else $error("chip select wrong");
   a_addr_ten_path: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (mode[3] == HPM_HOST && cfg_reg.mux_bus)
      |=> host_out.host_addr_bit_ten == $past(lvl[3]))
      else $error("address bit ten mismatch");
   a_reset_off: assert property (@(posedge clk_in)
      !rst_n_in |=> pin_oe_n_out == 4'hf && gpio_in_out == 4'h0)
      else $error("pins not disconnected after reset");
   a_gpio_drive: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (!cfg_reg.host_function_mode && cfg_reg.gpio_en[0]
       && cfg_reg.gpio_dir[0]) |=> !pin_oe_n_out[0])
      else $error("gpio output not driven");
   a_addr_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (cfg_reg.host_function_mode && cfg_reg.mux_bus) ##1
      (cfg_reg.host_function_mode && cfg_reg.mux_bus)
      |=> !host_out.host_addr_bit_zero)
      else $error("address zero taken in mux mode");

   // pin isolation, gpio path, host-active and address-zero checks
   a_active_on: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      cfg_reg.host_function_mode |-> ##2 host_active_out)
      else $error("host mode not active");
   a_active_off: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !cfg_reg.host_function_mode |-> ##2 !host_active_out)
      else $error("host mode active in gpio mode");
   a_host_no_drive: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      cfg_reg.host_function_mode |=> pin_oe_n_out == 4'hf)
      else $error("shared pin driven in host mode");
   a_gpio_off_pin: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (!cfg_reg.host_function_mode && !cfg_reg.gpio_en[0])
      |=> pin_oe_n_out[0] && !pin_out[0] && !gpio_in_out[0])
      else $error("disconnected pin not isolated");
   a_gpio_in_cap: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (!cfg_reg.host_function_mode && cfg_reg.gpio_en[2]
       && !cfg_reg.gpio_dir[2])
      |=> gpio_in_out[2] == $past(pin_in[2]))
      else $error("gpio input not captured");
   a_gpio_out_val: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (!cfg_reg.host_function_mode && cfg_reg.gpio_en[0]
       && cfg_reg.gpio_dir[0])
      |=> pin_out[0] == $past(cfg_reg.gpio_out[0]))
      else $error("gpio output value wrong");
   a_addr_zero_val: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (cfg_reg.host_function_mode && !cfg_reg.mux_bus)
      |-> ##2 host_out.host_addr_bit_zero ==
          $past(addr_zero_pin_in, 2))
      else $error("address zero not taken");

   c_host_mux: cover property (@(posedge clk_in) disable iff (!rst_n_in)
      host_active_out && cfg_reg.mux_bus);
   c_host_dbl: cover property (@(posedge clk_in) disable iff (!rst_n_in)
      host_active_out && cfg_reg.double_strobe);
   c_gpio_out: cover property (@(posedge clk_in) disable iff (!rst_n_in)
      pin_oe_n_out == 4'h0);
   c_host_single: cover property (@(posedge clk_in) disable iff (!rst_n_in)
      host_active_out && !cfg_reg.mux_bus && !cfg_reg.double_strobe);
   c_gpio_off: cover property (@(posedge clk_in) disable iff (!rst_n_in)
      !host_active_out && pin_oe_n_out == 4'hf);
endmodule

//--- tb/hpm_host_model.sv
// far-side bus model: external host driving the four shared pins
`timescale 1ns/10ps
module hpm_host_model
   import hpm_pkg::*;
(
   input  wire logic         clk_in,
   input  wire hpm_cfg_type  cfg_in,
   input  wire hpm_host_type want_in,
   input  wire logic         drive_in,
   input  wire logic [3:0]   dut_val_in,
   input  wire logic [3:0]   dut_oe_n_in,
   output logic [3:0]        pin_level_out
);
   logic [3:0] enc;
   logic [3:0] last_reg = 4'h0;

   // host-side encoding of wanted (active high) roles onto pin levels
   always_comb begin
      enc[0] = cfg_in.mux_bus ? want_in.host_addr_bit_nine
                              : want_in.host_addr_bit_two;
      enc[1] = cfg_in.double_strobe
             ? (want_in.host_read_strobe ~^ cfg_in.rd_pol_high)
             : want_in.host_read_write_dir;
      enc[2] = (cfg_in.double_strobe ? want_in.host_write_strobe
               : want_in.host_combined_strobe) ~^ cfg_in.ds_pol_high;
      enc[3] = cfg_in.mux_bus ? want_in.host_addr_bit_ten
             : (want_in.host_chip_select ~^ cfg_in.cs_pol_high);
      // wire level: device drive wins, then host drive (drive_in), else the line toggles every cycle
      for (int i = 0; i < 4; i++) begin
         pin_level_out[i] = !dut_oe_n_in[i] ? dut_val_in[i]
                          : drive_in ? enc[i] : ~last_reg[i];
      end
   end

   always @(posedge clk_in) begin
      last_reg <= pin_level_out;
   end
endmodule

//--- tb/test_hpm_top.sv
// testbench for the host port pin function select
`timescale 1ns/10ps
module test_hpm_top
   import hpm_pkg::*;
;
   `define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin \
      n_errors++; $display("Error %s exp %h got %h", nm, ex, gt); end end
   typedef struct {
      hpm_cfg_type  cfg;
      hpm_host_type want;
      logic         a0;
      hpm_host_type exp;
   } hpm_row_type;
   logic         clk_in = 1'b0;
   logic         rst_n_in = 1'b0;
   hpm_cfg_type  cfg = '0;
   hpm_host_type want = '0;
   logic         drive = 1'b0;
   logic         a0 = 1'b0;
   logic [3:0]   pin_lvl, pin_val, oe_n, gpio_in;
   hpm_host_type host;
   logic         active;
   int           n_errors = 0;
   int           checks = 0;
   hpm_row_type  rows [16];

   always #2 clk_in = ~clk_in;

   hpm_top DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .cfg_in(cfg),
      .pin_in(pin_lvl), .addr_zero_pin_in(a0), .pin_out(pin_val),
      .pin_oe_n_out(oe_n), .gpio_in_out(gpio_in), .host_out(host),
      .host_active_out(active));
   hpm_host_model far (.clk_in(clk_in), .cfg_in(cfg), .want_in(want),
      .drive_in(drive), .dut_val_in(pin_val), .dut_oe_n_in(oe_n),
      .pin_level_out(pin_lvl));

   function automatic hpm_host_type exp_host(hpm_cfg_type c,
                                             hpm_host_type w, logic z);
      hpm_host_type e;
      e = '0;
      if (c.mux_bus) begin
         e.host_addr_bit_nine = w.host_addr_bit_nine;
         e.host_addr_bit_ten  = w.host_addr_bit_ten;
      end else begin
         e.host_addr_bit_zero = z;
         e.host_addr_bit_two  = w.host_addr_bit_two;
         e.host_chip_select   = w.host_chip_select;
      end
      if (c.double_strobe) begin
         e.host_read_strobe  = w.host_read_strobe;
         e.host_write_strobe = w.host_write_strobe;
      end else begin
         e.host_read_write_dir  = w.host_read_write_dir;
         e.host_combined_strobe = w.host_combined_strobe;
      end
      return e;
   endfunction

   task automatic idle_check(string nm);
      `CHK({nm, " host"}, 9'h000, host)
      `CHK({nm, " active"}, 1'b0, active)
   endtask

   task automatic close_out();
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      #100000;
      n_errors++;
      close_out();
   end

   initial begin
      logic [3:0] en, dir;
      for (int i = 0; i < 16; i++) begin
         rows[i].cfg = '0;
         rows[i].cfg.host_function_mode = 1'b1;
         rows[i].cfg.mux_bus = i[0];
         rows[i].cfg.double_strobe = i[1];
         rows[i].cfg.rd_pol_high = i[2];
         rows[i].cfg.ds_pol_high = i[2] ^ i[3];
         rows[i].cfg.cs_pol_high = i[2] & i[3];
         rows[i].cfg.gpio_en = 4'hf;
         rows[i].cfg.gpio_dir = 4'hf;
         rows[i].cfg.gpio_out = 4'ha;
         rows[i].want = i[3] ? 9'h0aa : 9'h155;
         rows[i].a0 = ~i[3];
         rows[i].exp = exp_host(rows[i].cfg, rows[i].want, rows[i].a0);
      end
      repeat (8) @(posedge clk_in);
      @(negedge clk_in);
      rst_n_in = 1'b1;
      want = 9'h1ff;
      drive = 1'b1;
      a0 = 1'b1;
      repeat (6) @(negedge clk_in);
      `CHK("reset oe_n", 4'hf, oe_n)
      `CHK("reset pin_out", 4'h0, pin_val)
      `CHK("reset gpio_in", 4'h0, gpio_in)
      idle_check("reset");
      $display("test reset done");
      for (int i = 0; i < 16; i++) begin
         cfg = rows[i].cfg;
         want = rows[i].want;
         a0 = rows[i].a0;
         repeat (6) @(negedge clk_in);
         `CHK("host_out", rows[i].exp, host)
         `CHK("host_pol", rows[i].exp, host)
         `CHK("host active", 1'b1, active)
         `CHK("host oe_n", 4'hf, oe_n)
         $display("test row %0d done", i);
      end
      for (int k = 0; k < 3; k++) begin
         en = (k == 0) ? 4'he : 4'hf;
         dir = (k == 0) ? 4'ha : (k == 1) ? 4'h5 : 4'hf;
         cfg = '0;
         cfg.gpio_en = en;
         cfg.gpio_dir = dir;
         cfg.gpio_out = (k == 1) ? 4'h5 : 4'h8;
         want = k ? 9'h155 : 9'h1ff;
         repeat (6) @(negedge clk_in);
         `CHK("gpio oe_n", ~(en & dir), oe_n)
         `CHK("gpio pin_out", en & dir & cfg.gpio_out, pin_val)
         `CHK("gpio in", pin_lvl & en & ~dir, gpio_in)
         idle_check("gpio");
         $display("test gpio %0d done", k);
      end
      cfg = rows[0].cfg;
      want = rows[0].want;
      a0 = rows[0].a0;
      repeat (6) @(negedge clk_in);
      rst_n_in = 1'b0;
      repeat (2) @(negedge clk_in);
      `CHK("midreset oe_n", 4'hf, oe_n)
      idle_check("midreset");
      rst_n_in = 1'b1;
      repeat (6) @(negedge clk_in);
      `CHK("after reset host", rows[0].exp, host)
      $display("test midrun reset done");
      close_out();
   end
endmodule
